// ### src/sdp_top.sv
// Purpose: single-pin debug serial port front end and debug mode control
// Assumes: ref_clk 100 MHz; rst synchronous active high; pin pulled up
// Notes:   reset inputs other than rst come from outside and are resynced
`include "sdp_regs.svh"
module sdp_top
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        por_rst,
   input  wire logic        bor_rst,
   input  wire logic        ext_rst_n,
   input  wire logic        debug_serial_pin_in,
   output logic             debug_serial_pin_out,
   output logic             debug_serial_pin_oe,
   input  wire logic        debug_entry_request_wr,
   input  wire logic        debug_entry_request_bit,
   input  wire logic        breakpoint_instruction,
   input  wire logic        breakpoint_enable,
   input  wire logic        watch_match,
   input  wire logic        exec_request,
   input  wire logic        stop_mode,
   input  wire logic        halt_mode,
   input  wire logic        wdt_enable,
   input  wire sdp_pkg::sdp_byte_t tx_data,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   output sdp_pkg::sdp_byte_t rx_data,
   output logic             rx_valid,
   input  wire logic        rx_ready,
   output logic             rx_overrun,
   output logic             baud_locked,
   output logic             debug_mode,
   output logic             fetch_stall,
   output logic             halt_exit,
   output logic             wdt_refresh,
   output logic             clk_run,
   output logic             periph_run,
   output logic             sys_reset_req
);
   import sdp_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Timer reload: action fires when the count reaches zero
   function automatic logic [10:0] ticks(input logic [10:0] n);
      ticks = n - 11'h001;
   endfunction

   function automatic logic [10:0] half(input logic [9:0] n);
      half = {2'h0, n[9:1]};
   endfunction

   function automatic logic [10:0] full(input logic [9:0] n);
      full = {1'b0, n};
   endfunction

   // Open drain: enable high only when the bit is zero
   function automatic logic pull_low(input logic b);
      pull_low = ~b;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   sdp_state_t s;
   sdp_state_t next_s;
   logic       rst_any;
   logic       pin;
   logic       fall;
   logic       take;
   logic       enter;
   logic [9:0] meas_div;

   sdp_stream_if tx_fill ();
   sdp_stream_if tx_drain ();

   assign tx_fill.data  = tx_data;
   assign tx_fill.valid = tx_valid;
   assign tx_ready      = tx_fill.ready;
   assign tx_drain.ready = take;

   sdp_buf u_buf
   (
      .clk   (ref_clk),
      .rst   (rst_any),
      .fill  (tx_fill.snk),
      .drain (tx_drain.src)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      take = 1'b0;
      next_s.pin_sy  = {s.pin_sy[0], debug_serial_pin_in};
      next_s.por_sy  = {s.por_sy[0], por_rst};
      next_s.bor_sy  = {s.bor_sy[0], bor_rst};
      next_s.xrst_sy = {s.xrst_sy[0], ext_rst_n};
      rst_any = rst | s.por_sy[1] | s.bor_sy[1] | ~s.xrst_sy[1];
      pin  = s.pin_sy[1];
      fall = s.prev_pin & ~pin;
      next_s.prev_pin = pin;
      meas_div = s.meas[12:`SDP_CAL_SHIFT];
      if (s.timer != 11'h000)
      begin
         next_s.timer = s.timer - 11'h001;
      end

      // Debug mode: entries win over a clear in the same cycle
      enter = (debug_entry_request_wr & debug_entry_request_bit)
            | (breakpoint_instruction & breakpoint_enable)
            | watch_match;
      if (debug_entry_request_wr & ~debug_entry_request_bit)
      begin
         next_s.mode = 1'b0;
      end
      if (s.rst_seen)
      begin
         next_s.rst_seen = 1'b0;
         if (~pin)
         begin
            next_s.mode = 1'b1;
         end
      end
      if (enter)
      begin
         next_s.mode = 1'b1;
      end
      next_s.fetch_stall   = next_s.mode & ~exec_request;
      next_s.halt_exit     = next_s.mode & halt_mode;
      next_s.wdt_refresh   = next_s.mode & wdt_enable;
      next_s.clk_run       = ~stop_mode;
      next_s.periph_run    = ~stop_mode;
      next_s.sys_reset_req = stop_mode & ~pin;

      if (s.rx_valid & rx_ready)
      begin
         next_s.rx_valid = 1'b0;
      end

      // Single state machine keeps receive and transmit exclusive
      case (s.link)
         L_CAL_WAIT:
         begin
            // Silent until the first host character arrives
            if (fall)
            begin
               next_s.meas = 13'h0001;
               next_s.link = L_CAL_MEAS;
            end
         end
         L_CAL_MEAS:
         begin
            if (~pin)
            begin
               // Saturates so a stuck-low line cannot wrap the count
               if (s.meas != `SDP_MEAS_MAX)
               begin
                  next_s.meas = s.meas + 13'h0001;
               end
            end
            else if (meas_div >= `SDP_DIV_MIN &&
                     meas_div <= `SDP_DIV_MAX)
            begin
               next_s.div    = meas_div;
               next_s.locked = 1'b1;
               next_s.link   = L_IDLE;
            end
            else
            begin
               // Out of range: wait for another calibration character
               next_s.link = L_CAL_WAIT;
            end
         end
         L_IDLE:
         begin
            if (fall)
            begin
               next_s.timer = ticks(half(s.div));
               next_s.link  = L_RX_START;
            end
            else if (tx_drain.valid & pin)
            begin
               take = 1'b1;
               next_s.txreg = tx_drain.data;
               next_s.oe    = 1'b1;
               next_s.timer = ticks(full(s.div));
               next_s.link  = L_TX_START;
            end
         end
         L_RX_START:
         begin
            if (s.timer == 11'h000)
            begin
               // A start that is gone by mid-bit was a glitch
               if (~pin)
               begin
                  next_s.bitn  = 3'h0;
                  next_s.timer = ticks(full(s.div));
                  next_s.link  = L_RX_DATA;
               end
               else
               begin
                  next_s.link = L_IDLE;
               end
            end
         end
         L_RX_DATA:
         begin
            if (s.timer == 11'h000)
            begin
               next_s.shreg = {pin, s.shreg[7:1]};
               next_s.bitn  = s.bitn + 3'h1;
               next_s.timer = ticks(full(s.div));
               if (s.bitn == `SDP_LAST_BIT)
               begin
                  next_s.link = L_RX_STOP;
               end
            end
         end
         L_RX_STOP:
         begin
            if (s.timer == 11'h000)
            begin
               next_s.link = L_IDLE;
               // Low stop bit: framing fault, byte dropped
               if (pin)
               begin
                  if (s.rx_valid & ~rx_ready)
                  begin
                     next_s.rx_overrun = 1'b1;
                  end
                  next_s.rx_data  = s.shreg;
                  next_s.rx_valid = 1'b1;
               end
            end
         end
         L_TX_START:
         begin
            if (s.timer == 11'h000)
            begin
               next_s.oe    = pull_low(s.txreg[0]);
               next_s.txreg = {1'b0, s.txreg[7:1]};
               next_s.bitn  = 3'h0;
               next_s.timer = ticks(full(s.div));
               next_s.link  = L_TX_DATA;
            end
         end
         L_TX_DATA:
         begin
            if (s.timer == 11'h000)
            begin
               if (s.bitn == `SDP_LAST_BIT)
               begin
                  // Release the line for one and a half bit periods
                  next_s.oe    = 1'b0;
                  next_s.timer = ticks(full(s.div) + half(s.div));
                  next_s.link  = L_TX_STOP;
               end
               else
               begin
                  next_s.oe    = pull_low(s.txreg[0]);
                  next_s.txreg = {1'b0, s.txreg[7:1]};
                  next_s.bitn  = s.bitn + 3'h1;
                  next_s.timer = ticks(full(s.div));
               end
            end
         end
         L_TX_STOP:
         begin
            if (s.timer == 11'h000)
            begin
               next_s.link = L_IDLE;
            end
         end
         default:
         begin
            next_s.link = L_CAL_WAIT;
         end
      endcase

      // Synchronisers keep running so the strap is valid at release
      if (rst_any)
      begin
         next_s = '0;
         next_s.pin_sy  = {s.pin_sy[0], debug_serial_pin_in};
         next_s.por_sy  = {s.por_sy[0], por_rst};
         next_s.bor_sy  = {s.bor_sy[0], bor_rst};
         next_s.xrst_sy = {s.xrst_sy[0], ext_rst_n};
         next_s.rst_seen   = 1'b1;
         next_s.link       = L_CAL_WAIT;
         next_s.prev_pin   = `SDP_LINE_IDLE;
         next_s.drive      = `SDP_DRIVE_LEVEL;
         next_s.clk_run    = 1'b1;
         next_s.periph_run = 1'b1;
         take = 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      s <= next_s;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign debug_serial_pin_out = s.drive;
   assign debug_serial_pin_oe  = s.oe;
   assign rx_data       = s.rx_data;
   assign rx_valid      = s.rx_valid;
   assign rx_overrun    = s.rx_overrun;
   assign baud_locked   = s.locked;
   assign debug_mode    = s.mode;
   assign fetch_stall   = s.fetch_stall;
   assign halt_exit     = s.halt_exit;
   assign wdt_refresh   = s.wdt_refresh;
   assign clk_run       = s.clk_run;
   assign periph_run    = s.periph_run;
   assign sys_reset_req = s.sys_reset_req;
endmodule

// ### src/sdp_regs.svh
`ifndef SDP_REGS_SVH
`define SDP_REGS_SVH
// Purpose: constants of the single-pin debug serial port
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes:   no software-visible registers; control arrives on ports
//
// Functional notes
// - In debug mode stall instruction fetch unless an execute is requested.
// - Clock and enabled peripherals keep running in debug mode, except stop.
// - Entering debug mode forces the core out of halt.
// - Debug mode keeps refreshing the enabled watchdog.
// - Writing the debug entry request bit as one enters debug mode.
// - An enabled breakpoint instruction enters debug mode.
// - A watchpoint match enters debug mode.
// - Debug pin low when reset ends enters debug mode.
// - Writing the debug entry request bit as zero leaves debug mode.
// - Power-on, brownout or external reset pin ends debug mode.
// - Debug pin low during stop requests a full system reset.
// - Frame: one start, eight data bits LSB first, 1.5 stop bits.
// - After reset stay silent until host data has been received.
// - Measure the eight-bit low period and set the baud generator.
// - Detector runs on system clock, down to clock divided by 512.
// - Link works up to clock divided by four on clean signals.
// - Half duplex: never transmit and receive at once.
// - Pin is open drain: drive only low, otherwise release.

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define SDP_CLK_PERIOD_NS 10
`define SDP_CAL_SHIFT     3
`define SDP_DIV_MIN       10'h004
`define SDP_DIV_MAX       10'h200
`define SDP_MEAS_MAX      13'h1FFF
`define SDP_LAST_BIT      3'h7

// ----------------------------------------------------------------
// Reset values and buffer full count
// ----------------------------------------------------------------
`define SDP_LINE_IDLE     1'b1
`define SDP_DRIVE_LEVEL   1'b0
`define SDP_BUF_FULL      2'h2

`endif

// ### src/sdp_pkg.sv
// Purpose: types of the single-pin debug serial port
// Assumes: sdp_regs.svh holds the numbers
// Notes:   link states are one-hot
`include "sdp_regs.svh"
package sdp_pkg;
   typedef logic [7:0] sdp_byte_t;

   typedef enum logic [8:0]
   {
      L_CAL_WAIT = 9'h001,
      L_CAL_MEAS = 9'h002,
      L_IDLE     = 9'h004,
      L_RX_START = 9'h008,
      L_RX_DATA  = 9'h010,
      L_RX_STOP  = 9'h020,
      L_TX_START = 9'h040,
      L_TX_DATA  = 9'h080,
      L_TX_STOP  = 9'h100
   } sdp_link_t;

   typedef struct packed
   {
      logic [1:0] pin_sy;
      logic [1:0] por_sy;
      logic [1:0] bor_sy;
      logic [1:0] xrst_sy;
      logic       rst_seen;
      logic       mode;
      sdp_link_t  link;
      logic       prev_pin;
      logic [12:0] meas;
      logic [9:0] div;
      logic [10:0] timer;
      logic [2:0] bitn;
      sdp_byte_t  shreg;
      sdp_byte_t  txreg;
      sdp_byte_t  rx_data;
      logic       rx_valid;
      logic       rx_overrun;
      logic       locked;
      logic       oe;
      logic       drive;
      logic       fetch_stall;
      logic       halt_exit;
      logic       wdt_refresh;
      logic       clk_run;
      logic       periph_run;
      logic       sys_reset_req;
   } sdp_state_t;

   typedef struct packed
   {
      logic [1:0][7:0] mem;
      logic            wr_ptr;
      logic            rd_ptr;
      logic [1:0]      cnt;
      logic            in_rdy;
   } sdp_buf_t;
endpackage

// ### src/sdp_stream_if.sv
// Purpose: byte stream with valid and ready
// Assumes: both ends on ref_clk
// Notes:   a word moves when valid and ready are both high
interface sdp_stream_if;
   import sdp_pkg::*;
   sdp_byte_t data;
   logic      valid;
   logic      ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// ### src/sdp_buf.sv
// Purpose: two-entry buffer in the transmit path
// Assumes: synchronous active-high reset
// Notes:   fill ready comes from a flip-flop
`include "sdp_regs.svh"
module sdp_buf
(
   input wire logic   clk,
   input wire logic   rst,
   sdp_stream_if.snk  fill,
   sdp_stream_if.src  drain
);
   import sdp_pkg::*;

   sdp_buf_t s;
   sdp_buf_t next_s;
   logic     push;
   logic     pop;

   assign fill.ready  = s.in_rdy;
   assign drain.valid = (s.cnt != 2'h0);
   assign drain.data  = s.mem[s.rd_ptr];

   always_comb
   begin
      next_s = s;
      push = fill.valid & s.in_rdy;
      pop  = drain.ready & (s.cnt != 2'h0);
      if (push)
      begin
         next_s.mem[s.wr_ptr] = fill.data;
         next_s.wr_ptr = ~s.wr_ptr;
      end
      if (pop)
      begin
         next_s.rd_ptr = ~s.rd_ptr;
      end
      case ({push, pop})
         2'b10:   next_s.cnt = s.cnt + 2'h1;
         2'b01:   next_s.cnt = s.cnt - 2'h1;
         default: next_s.cnt = s.cnt;
      endcase
      next_s.in_rdy = (next_s.cnt != `SDP_BUF_FULL);
      if (rst)
      begin
         next_s = '0;
         next_s.in_rdy = 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      s <= next_s;
   end
endmodule

// ### sim/sdp_checker.sv
// Purpose: assertions on the debug serial port ports
// Assumes: bound to sdp_top, inputs synced by two flops
// Notes:   all checks on ref_clk, disabled in rst
module sdp_checker
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic por_rst,
   input wire logic bor_rst,
   input wire logic ext_rst_n,
   input wire logic debug_serial_pin_in,
   input wire logic debug_serial_pin_out,
   input wire logic debug_serial_pin_oe,
   input wire logic debug_entry_request_wr,
   input wire logic debug_entry_request_bit,
   input wire logic breakpoint_instruction,
   input wire logic breakpoint_enable,
   input wire logic watch_match,
   input wire logic exec_request,
   input wire logic stop_mode,
   input wire logic halt_mode,
   input wire logic wdt_enable,
   input wire logic baud_locked,
   input wire logic debug_mode,
   input wire logic fetch_stall,
   input wire logic halt_exit,
   input wire logic wdt_refresh,
   input wire logic clk_run,
   input wire logic periph_run,
   input wire logic sys_reset_req
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // ------------------------------
   // Debug mode
   // ------------------------------
   stall_fetch_a :
      assert property ((debug_mode && !exec_request)[*2] |-> fetch_stall)
      else $error("fetch not stalled");
   clock_stop_a :
      assert property (stop_mode[*2] |-> !clk_run && !periph_run)
      else $error("clock runs in stop");
   halt_leave_a :
      assert property ((debug_mode && halt_mode)[*2] |-> halt_exit)
      else $error("halt not left");
   wdt_keep_a :
      assert property ((debug_mode && wdt_enable)[*2] |-> wdt_refresh)
      else $error("watchdog not refreshed");
   enter_debug_a :
      assert property (debug_entry_request_wr && debug_entry_request_bit
         || breakpoint_instruction && breakpoint_enable || watch_match
         |=> debug_mode)
      else $error("debug mode not entered");
   bp_off_a :
      assert property (breakpoint_instruction && !breakpoint_enable
         && !debug_mode && !watch_match && !debug_entry_request_wr
         |=> !debug_mode)
      else $error("disabled breakpoint entered");
   leave_debug_a :
      assert property (debug_entry_request_wr && !debug_entry_request_bit
         && !breakpoint_instruction && !watch_match |=> !debug_mode)
      else $error("debug mode not left");
   reset_exit_a :
      assert property ((por_rst || bor_rst || !ext_rst_n)[*4]
         |-> !debug_mode)
      else $error("reset kept debug mode");
   stop_wake_a :
      assert property ((stop_mode && !debug_serial_pin_in)[*4]
         |-> sys_reset_req)
      else $error("no system reset request");

   // ------------------------------
   // Pin
   // ------------------------------
   quiet_start_a :
      assert property (!baud_locked |-> !debug_serial_pin_oe)
      else $error("sent before calibration");
   open_drain_a :
      assert property (debug_serial_pin_oe |-> !debug_serial_pin_out)
      else $error("pin driven high");
   cover property ($rose(debug_mode));
   cover property ($rose(baud_locked));
   cover property ($rose(debug_serial_pin_oe));
   cover property ($rose(sys_reset_req));
endmodule

// ### sim/sdp_host_model.sv
// Purpose: host end of the single-wire debug link
// Assumes: bit time in clock cycles, pull-up on the wire
// Notes:   only ever pulls the line low
module sdp_host_model
(
   input wire logic ref_clk,
   input wire logic line,
   output logic     drive_low
);
   timeunit 1ns;
   timeprecision 1ns;
   initial drive_low = 1'h0;

   task automatic hold(input logic v);
      drive_low = v;
   endtask

   // Waits for a released line so it never starts while the line is held low
   task automatic send(input logic [7:0] b, input int bc);
      logic [8:0] f;
      f = {b, 1'h0};
      @(negedge ref_clk);
      while (!line)
         @(negedge ref_clk);
      for (int i = 0; i < 9; i++)
      begin
         drive_low = !f[i];
         repeat (bc) @(negedge ref_clk);
      end
      drive_low = 1'h0;
      repeat (bc * 3 / 2) @(negedge ref_clk);
   endtask

   task automatic recv(output logic [7:0] b, output logic ok,
                       input int bc);
      int n;
      n = 0;
      b = 8'h00;
      while (line && n < 20000)
      begin
         @(negedge ref_clk);
         n++;
      end
      repeat (bc / 2) @(negedge ref_clk);
      ok = !line && n < 20000;
      for (int i = 0; i < 8; i++)
      begin
         repeat (bc) @(negedge ref_clk);
         b[i] = line;
      end
      repeat (bc) @(negedge ref_clk);
      ok = ok && line;
      repeat (bc / 2) @(negedge ref_clk);
      ok = ok && line;
   endtask
endmodule

// ### sim/testbench.sv
// Purpose: self-checking bench for the debug serial port
// Assumes: host model on the pin, pull-up on the wire
// Notes:   bit periods given in clock cycles
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import sdp_pkg::*;
   logic      ref_clk, rst, por_rst, bor_rst, ext_rst_n, pin, oe, po;
   logic      wr, wbit, bp, bpen, watch, exec, stop, halt, wdt, txv;
   logic      txr, rxv, rxr, ovr, lock, mode, stall, hx, wref, crun;
   logic      prun, sreq, host_low;
   sdp_byte_t txd, rxd;
   int        bad_count, n_compared;

   // Open drain wire with pull-up
   assign pin = !(oe || host_low);
   always #5 ref_clk = ~ref_clk;

   sdp_top DUT
   (
      .ref_clk(ref_clk), .rst(rst), .por_rst(por_rst), .bor_rst(bor_rst),
      .ext_rst_n(ext_rst_n), .debug_serial_pin_in(pin),
      .debug_serial_pin_out(po), .debug_serial_pin_oe(oe),
      .debug_entry_request_wr(wr), .debug_entry_request_bit(wbit),
      .breakpoint_instruction(bp), .breakpoint_enable(bpen),
      .watch_match(watch), .exec_request(exec), .stop_mode(stop),
      .halt_mode(halt), .wdt_enable(wdt), .tx_data(txd), .tx_valid(txv),
      .tx_ready(txr), .rx_data(rxd), .rx_valid(rxv), .rx_ready(rxr),
      .rx_overrun(ovr), .baud_locked(lock), .debug_mode(mode),
      .fetch_stall(stall), .halt_exit(hx), .wdt_refresh(wref),
      .clk_run(crun), .periph_run(prun), .sys_reset_req(sreq)
   );
   sdp_host_model host (.ref_clk(ref_clk), .line(pin), .drive_low(host_low));

   // ------------------------------
   // Helpers
   // ------------------------------
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   task automatic chk_byte(input sdp_byte_t got, input sdp_byte_t exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   task automatic pulse(input logic w, v, b, e, m);
      wr = w;
      wbit = v;
      bp = b;
      bpen = e;
      watch = m;
      tick(1);
      {wr, bp, watch} = 3'h0;
      tick(2);
   endtask

   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ------------------------------
   // Tests
   // ------------------------------
   task automatic t_idle();
      tick(40);
      chk_bit(oe | lock | mode, 1'h0);
      chk_bit(crun, 1'h1);
      $display("test idle done");
   endtask

   task automatic t_cal(input int bc);
      host.send(8'h80, bc);
      tick(4);
      chk_bit(lock, 1'h1);
      chk_bit(rxv, 1'h0);
      $display("test calibrate done");
   endtask

   task automatic t_rx(input int bc);
      sdp_byte_t v[4];
      v = '{8'h01, 8'hA5, 8'h7E, 8'hFF};
      foreach (v[i])
      begin
         host.send(v[i], bc);
         chk_bit(rxv, 1'h1);
         chk_byte(rxd, v[i]);
         rxr = 1'h1;
         tick(1);
         rxr = 1'h0;
         tick(1);
         chk_bit(rxv, 1'h0);
      end
      // Two bytes with no read: second one overruns the first
      chk_bit(ovr, 1'h0);
      host.send(8'h3C, bc);
      host.send(8'hC3, bc);
      chk_bit(ovr, 1'h1);
      chk_byte(rxd, 8'hC3);
      rxr = 1'h1;
      tick(1);
      rxr = 1'h0;
      tick(1);
      chk_bit(rxv, 1'h0);
      $display("test receive done");
   endtask

   task automatic t_tx(input int bc);
      sdp_byte_t v[4];
      sdp_byte_t got;
      logic      ok, full;
      v = '{8'h55, 8'h00, 8'hC3, 8'h80};
      full = 1'h0;
      fork
         begin
            foreach (v[i])
            begin
               txd = v[i];
               txv = 1'h1;
               while (!txr)
               begin
                  full = 1'h1;
                  tick(1);
               end
               tick(1);
            end
            txv = 1'h0;
         end
         foreach (v[i])
         begin
            host.recv(got, ok, bc);
            chk_bit(ok, 1'h1);
            chk_byte(got, v[i]);
         end
      join
      chk_bit(full & txr, 1'h1);
      chk_bit(po, 1'h0);
      $display("test transmit done");
   endtask

   task automatic t_modes();
      for (int k = 0; k < 4; k++)
      begin
         pulse(k == 0, 1'h1, k[0], k == 1, k == 2);
         chk_bit(mode, k != 3);
         chk_bit(stall, k != 3);
         {exec, halt, wdt} = 3'h7;
         tick(2);
         chk_bit(stall, 1'h0);
         chk_bit(hx, k != 3);
         chk_bit(wref, k != 3);
         chk_bit(crun & prun, 1'h1);
         {exec, halt, wdt} = 3'h0;
         pulse(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
         chk_bit(mode, 1'h0);
      end
      $display("test modes done");
   endtask

   task automatic t_resets();
      for (int k = 0; k < 3; k++)
      begin
         pulse(1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
         chk_bit(mode, 1'h1);
         por_rst = (k == 0);
         bor_rst = (k == 1);
         ext_rst_n = (k != 2);
         tick(5);
         chk_bit(mode | lock, 1'h0);
         {por_rst, bor_rst, ext_rst_n} = 3'h1;
         tick(6);
         chk_bit(mode, 1'h0);
      end
      $display("test resets done");
   endtask

   task automatic t_stop();
      stop = 1'h1;
      tick(3);
      chk_bit(crun | prun | sreq, 1'h0);
      host.hold(1'h1);
      tick(5);
      chk_bit(sreq, 1'h1);
      host.hold(1'h0);
      stop = 1'h0;
      tick(4);
      chk_bit(crun, 1'h1);
      $display("test stop done");
   endtask

   task automatic t_strap();
      host.hold(1'h1);
      rst = 1'h1;
      tick(5);
      rst = 1'h0;
      tick(3);
      host.hold(1'h0);
      tick(3);
      chk_bit(mode, 1'h1);
      $display("test strap done");
   endtask

   initial
   begin
      {ref_clk, por_rst, bor_rst, wr, wbit, bp, bpen, watch} = 8'h00;
      {exec, stop, halt, wdt, txv, rxr, txd} = 14'h0000;
      {rst, ext_rst_n} = 2'h3;
      bad_count = 0;
      n_compared = 0;
      tick(5);
      rst = 1'h0;
      t_idle();
      t_cal(16);
      t_rx(16);
      t_tx(16);
      t_modes();
      t_resets();
      t_stop();
      t_strap();
      t_cal(512);
      t_rx(512);
      complete_run();
   end

   // Whole run needs about 40000 cycles
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      bad_count++;
      complete_run();
   end
endmodule

bind sdp_top sdp_checker u_chk
(
   .ref_clk, .rst, .por_rst, .bor_rst, .ext_rst_n, .debug_serial_pin_in,
   .debug_serial_pin_out, .debug_serial_pin_oe, .debug_entry_request_wr,
   .debug_entry_request_bit, .breakpoint_instruction, .breakpoint_enable,
   .watch_match, .exec_request, .stop_mode, .halt_mode, .wdt_enable,
   .baud_locked, .debug_mode, .fetch_stall, .halt_exit, .wdt_refresh,
   .clk_run, .periph_run, .sys_reset_req
);
